// ===== design/cls_defines.svh
// constants for the cold load threshold switchover block
`ifndef CLS_DEFINES_SVH
`define CLS_DEFINES_SVH
// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define CLS_CLK_HZ 50000000
`define CLS_TICK_S 1
`define CLS_SEC_CYC (`CLS_TICK_S * `CLS_CLK_HZ)
// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define CLS_OFF_CTRL 12'h000
`define CLS_OFF_OPEN 12'h004
`define CLS_OFF_ACT 12'h008
`define CLS_OFF_STOP 12'h00C
`define CLS_OFF_STAT 12'h010
// ---------------------------------------------------------------
// control bit positions
// ---------------------------------------------------------------
`define CLS_B_ON 0
`define CLS_B_CRIT 1
`define CLS_B_STOPINF 4
`define CLS_B_EUNIQ 5
// ---------------------------------------------------------------
// reset values and limits, whole seconds
// ---------------------------------------------------------------
`define CLS_CTRL_DEF 6'h00
`define CLS_OPEN_DEF 15'h0E10
`define CLS_OPEN_MAX 15'h5460
`define CLS_ACT_DEF 15'h0E10
`define CLS_ACT_MAX 15'h5460
`define CLS_ACT_MIN 15'h0001
`define CLS_STOP_DEF 10'h258
`define CLS_STOP_MAX 10'h258
`define CLS_STOP_MIN 10'h001
`endif

// ===== design/cls_pkg.sv
// types for the cold load threshold switchover block
package cls_pkg;
    // switchover sequence, gray along idle-open-dead-active-hold
    typedef enum logic [2:0] {
        S_IDLE = 3'h0,
        S_OPENW = 3'h1,
        S_DYND = 3'h3,
        S_ACTIVE = 3'h2,
        S_HOLD = 3'h6
    } cls_state_t;
endpackage : cls_pkg

// ===== design/cls_switchover.sv
// cold load threshold switchover supervisor with apb registers
//
// The placing of the registers and register access over APB were chosen for this implementation.
`timescale 1ns/100ps
`include "cls_defines.svh"
module cls_switchover #(
    parameter int NSTG = 8,
    parameter int SEC_CYC = `CLS_SEC_CYC,
    parameter bit SCOPE_INCLUDED = 1'b1
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clkEn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [2:0] breakerClosedPin,
    input wire logic [2:0] currentFlow,
    input wire logic coldloadBlockIn,
    input wire logic fastResetBlockIn,
    input wire logic anyPickup,
    input wire logic [NSTG-1:0] stageDropout,
    output logic phaseDynamicActive,
    output logic residualDynamicActive,
    output logic earthDynamicActive,
    output logic functionOffFlag,
    output logic functionBlockedFlag,
    output logic functionRunningFlag,
    output logic stageTimerRestart,
    output cls_pkg::cls_state_t stateOut
);
    import cls_pkg::*;

    // ---------------------------------------------------------------
    // pin synchronisers
    // ---------------------------------------------------------------
    logic [4:0] sync1_r;
    logic [4:0] sync2_r;
    logic [2:0] brkClosed;
    logic blkSync;
    logic frBlkSync;

    // two flops for breaker contacts and block inputs
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_r <= 5'h00;
            sync2_r <= 5'h00;
        end else if (clkEn) begin
            sync1_r <= {fastResetBlockIn, coldloadBlockIn, breakerClosedPin};
            sync2_r <= sync1_r;
        end
    end
    assign brkClosed = sync2_r[2:0]; // position from breaker
    assign blkSync = sync2_r[3];
    assign frBlkSync = sync2_r[4];

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    logic [5:0] ctrl_r;
    logic [14:0] openDelay_r;
    logic [14:0] activeTime_r;
    logic [9:0] stopTime_r;
    logic [31:0] prdata_r;
    logic [31:0] statusWord;
    logic wrEn;
    logic rdSetup;
    logic hitCtrl, hitOpen, hitAct, hitStop, hitStat, hitAny;
    logic [14:0] wrOpen;
    logic [14:0] wrAct;
    logic [9:0] wrStop;
    logic [31:0] rdMux;

    // address decode and write clamping
    assign hitCtrl = (paddr == `CLS_OFF_CTRL);
    assign hitOpen = (paddr == `CLS_OFF_OPEN);
    assign hitAct = (paddr == `CLS_OFF_ACT);
    assign hitStop = (paddr == `CLS_OFF_STOP);
    assign hitStat = (paddr == `CLS_OFF_STAT);
    assign hitAny = hitCtrl | hitOpen | hitAct | hitStop | hitStat;
    assign wrEn = psel & penable & pwrite & clkEn & hitAny;
    assign rdSetup = psel & ~penable & ~pwrite & clkEn;
    assign wrOpen = (pwdata[31:15] != 17'h00000 || pwdata[14:0] > `CLS_OPEN_MAX) ?
                    `CLS_OPEN_MAX : pwdata[14:0];
    assign wrAct = (pwdata[31:15] != 17'h00000 || pwdata[14:0] > `CLS_ACT_MAX) ? `CLS_ACT_MAX :
                   (pwdata[14:0] < `CLS_ACT_MIN) ? `CLS_ACT_MIN : pwdata[14:0];
    assign wrStop = (pwdata[31:10] != 22'h000000 || pwdata[9:0] > `CLS_STOP_MAX) ? `CLS_STOP_MAX :
                    (pwdata[9:0] < `CLS_STOP_MIN) ? `CLS_STOP_MIN : pwdata[9:0];
    assign rdMux = hitCtrl ? {26'h0000000, ctrl_r} :
                   hitOpen ? {17'h00000, openDelay_r} :
                   hitAct ? {17'h00000, activeTime_r} :
                   hitStop ? {22'h000000, stopTime_r} :
                   hitStat ? statusWord : 32'h00000000;
    assign pready = clkEn;
    assign pslverr = psel & penable & ~hitAny;
    assign prdata = prdata_r;

    // setting registers, default off and current criterion
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_r <= `CLS_CTRL_DEF;
            openDelay_r <= `CLS_OPEN_DEF;
            activeTime_r <= `CLS_ACT_DEF;
            stopTime_r <= `CLS_STOP_DEF;
        end else if (wrEn) begin
            if (hitCtrl) ctrl_r <= pwdata[5:0];
            if (hitOpen) openDelay_r <= wrOpen;
            if (hitAct) activeTime_r <= wrAct;
            if (hitStop) stopTime_r <= wrStop;
        end
    end

    // read data captured in the setup cycle
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata_r <= 32'h00000000;
        end else if (rdSetup) begin
            prdata_r <= rdMux;
        end
    end

    // ---------------------------------------------------------------
    // de-energisation detection
    // ---------------------------------------------------------------
    logic [2:0] critBrk;
    logic [2:0] grpDead;
    logic dead;
    logic live;
    logic enabled;
    logic runOk;

    // per group criterion, earth breaker only if unambiguous
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : gGrp
            if (g == 2) begin : gEarth
                assign critBrk[g] = ctrl_r[`CLS_B_CRIT + g] & ctrl_r[`CLS_B_EUNIQ];
            end else begin : gOther
                assign critBrk[g] = ctrl_r[`CLS_B_CRIT + g];
            end
            // signals arrive already bound to the group's side
            assign grpDead[g] = critBrk[g] ? ~brkClosed[g] : ~currentFlow[g];
        end
    endgenerate
    assign dead = &grpDead;
    assign live = ~dead;
    assign enabled = SCOPE_INCLUDED & ctrl_r[`CLS_B_ON];
    assign runOk = enabled & ~blkSync;

    // ---------------------------------------------------------------
    // second tick prescaler
    // ---------------------------------------------------------------
    logic [31:0] preCnt_r;
    logic tick;

    // one tick per second of core clock
    assign tick = clkEn & (preCnt_r == 32'(SEC_CYC - 1));
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            preCnt_r <= 32'h00000000;
        end else if (clkEn) begin
            preCnt_r <= tick ? 32'h00000000 : preCnt_r + 32'h00000001;
        end
    end

    // ---------------------------------------------------------------
    // switchover sequence
    // ---------------------------------------------------------------
    cls_state_t state_r, state_nxt;
    logic [14:0] secCnt_r, secCnt_nxt;
    logic [9:0] fastCnt_r;
    logic fastHold;
    logic fastStart;
    logic fastDone;
    logic dynamic;

    assign fastHold = ctrl_r[`CLS_B_STOPINF] | blkSync | frBlkSync;
    assign fastStart = |stageDropout;
    assign fastDone = ~fastHold & (fastCnt_r >= stopTime_r);
    assign dynamic = (state_r == S_DYND) | (state_r == S_ACTIVE) | (state_r == S_HOLD);

    // next state and seconds counter
    always_comb begin
        state_nxt = state_r;
        secCnt_nxt = secCnt_r;
        unique case (state_r)
            S_IDLE: begin
                if (dead) begin
                    state_nxt = S_OPENW; // normal kept while open delay runs
                    secCnt_nxt = openDelay_r;
                end
            end
            S_OPENW: begin
                if (live) begin
                    state_nxt = S_IDLE; // closed before expiry
                end else if (secCnt_r == 15'h0000) begin
                    state_nxt = S_DYND;
                end else if (tick) begin
                    secCnt_nxt = secCnt_r - 15'h0001;
                end
            end
            S_DYND: begin
                if (live) begin
                    state_nxt = S_ACTIVE;
                    secCnt_nxt = activeTime_r;
                end
            end
            S_ACTIVE: begin
                if (secCnt_r == 15'h0000 || fastDone) begin
                    state_nxt = anyPickup ? S_HOLD : S_IDLE;
                end else if (tick) begin
                    secCnt_nxt = secCnt_r - 15'h0001;
                end
            end
            S_HOLD: begin
                if (!anyPickup) begin
                    state_nxt = S_IDLE;
                end
            end
            default: begin
                state_nxt = S_IDLE;
            end
        endcase
        if (!runOk) begin
            state_nxt = S_IDLE;
            secCnt_nxt = 15'h0000;
        end
    end

    // state, idle with normal settings after reset
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= S_IDLE;
            secCnt_r <= 15'h0000;
        end else if (clkEn) begin
            state_r <= state_nxt;
            secCnt_r <= secCnt_nxt;
        end
    end

    // fast reset timer, restarts whenever no stage shows dropout
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            fastCnt_r <= 10'h000;
        end else if (clkEn) begin
            if (fastHold || !fastStart || state_r != S_ACTIVE) begin
                fastCnt_r <= 10'h000;
            end else if (tick && fastCnt_r != `CLS_STOP_MAX) begin
                fastCnt_r <= fastCnt_r + 10'h001;
            end
        end
    end

    // ---------------------------------------------------------------
    // indications
    // ---------------------------------------------------------------
    logic dyn_r;
    logic offFlag_r;
    logic blkFlag_r;
    logic runFlag_r;
    logic restart_r;

    // one alternative-set select shared by all groups, no setting group input
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            dyn_r <= 1'b0;
            offFlag_r <= 1'b1;
            blkFlag_r <= 1'b0;
            runFlag_r <= 1'b0;
            restart_r <= 1'b0;
        end else if (clkEn) begin
            dyn_r <= dynamic & runOk;
            offFlag_r <= ~enabled;
            blkFlag_r <= enabled & blkSync;
            runFlag_r <= runOk;
            restart_r <= blkSync & enabled & dynamic & anyPickup;
        end
    end
    assign phaseDynamicActive = dyn_r;
    assign residualDynamicActive = dyn_r;
    assign earthDynamicActive = dyn_r;
    assign functionOffFlag = offFlag_r;
    assign functionBlockedFlag = blkFlag_r;
    assign functionRunningFlag = runFlag_r;
    assign stageTimerRestart = restart_r;
    assign stateOut = state_r;
    assign statusWord = {21'h000000, restart_r, runFlag_r, blkFlag_r, offFlag_r, dyn_r, grpDead, state_r};

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    sequence s_blockInFault;
        clkEn && blkSync && enabled && dynamic && anyPickup;
    endsequence
    property p_restart;
        @(posedge core_clk) disable iff (!rst_n)
        s_blockInFault |=> stageTimerRestart ##1 (state_r == S_IDLE);
    endproperty
    a_restart: assert property (p_restart) else $error("stage restart missing");
    property p_block;
        @(posedge core_clk) disable iff (!rst_n)
        (clkEn && blkSync) |=> (state_r == S_IDLE && secCnt_r == 15'h0000);
    endproperty
    a_block: assert property (p_block) else $error("block did not reset");
    property p_earlyClose;
        @(posedge core_clk) disable iff (!rst_n)
        (clkEn && runOk && state_r == S_OPENW && live) |=> (state_r == S_IDLE);
    endproperty
    a_earlyClose: assert property (p_earlyClose) else $error("early close kept dynamic");
    property p_openExpire;
        @(posedge core_clk) disable iff (!rst_n)
        (clkEn && runOk && state_r == S_OPENW && dead && secCnt_r == 15'h0000)
        |=> (state_r == S_DYND) ##1 (clkEn ? phaseDynamicActive || !runOk || state_r == S_IDLE : 1'b1);
    endproperty
    a_openExpire: assert property (p_openExpire) else $error("open delay expiry missed");
    property p_reenergise;
        @(posedge core_clk) disable iff (!rst_n)
        (clkEn && runOk && state_r == S_DYND && live) |=> (state_r == S_ACTIVE && secCnt_r == $past(activeTime_r));
    endproperty
    a_reenergise: assert property (p_reenergise) else $error("active window not started");
    property p_hold;
        @(posedge core_clk) disable iff (!rst_n)
        (clkEn && runOk && state_r == S_HOLD && anyPickup) |=> (state_r == S_HOLD);
    endproperty
    a_hold: assert property (p_hold) else $error("dynamic values dropped in fault");
    property p_fastHold;
        @(posedge core_clk) disable iff (!rst_n)
        (clkEn && fastHold) |=> (fastCnt_r == 10'h000);
    endproperty
    a_fastHold: assert property (p_fastHold) else $error("fast timer not held");
    property p_idleNormal;
        @(posedge core_clk) disable iff (!rst_n)
        (clkEn && state_r == S_IDLE) |=> !phaseDynamicActive && !earthDynamicActive;
    endproperty
    a_idleNormal: assert property (p_idleNormal) else $error("dynamic active while idle");
    property p_off;
        @(posedge core_clk) disable iff (!rst_n)
        (clkEn && !enabled) |=> functionOffFlag && !functionRunningFlag && !residualDynamicActive;
    endproperty
    a_off: assert property (p_off) else $error("off indication wrong");
    // dead equipment starts the open delay with normal values still selected
    property p_openStart;
        @(posedge core_clk) disable iff (!rst_n)
        (clkEn && runOk && state_r == S_IDLE && dead)
        |=> (state_r == S_OPENW && secCnt_r == $past(openDelay_r) && !phaseDynamicActive);
    endproperty
    a_openStart: assert property (p_openStart) else $error("open delay not started");
    // fast reset with no pickup ends the window at once
    property p_fastEnd;
        @(posedge core_clk) disable iff (!rst_n)
        (clkEn && runOk && state_r == S_ACTIVE && fastDone && !anyPickup) |=> (state_r == S_IDLE);
    endproperty
    a_fastEnd: assert property (p_fastEnd) else $error("fast reset did not end window");
endmodule : cls_switchover

// ===== test/cls_load_model.sv
// far-side model: breaker auxiliary contacts and overcurrent stages
`timescale 1ns/100ps
module cls_load_model #(
    parameter int NSTG = 8
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [2:0] breakerCmd,
    input wire logic [2:0] loadOn,
    input wire logic faultOn,
    input wire logic [NSTG-1:0] pickMask,
    input wire logic stageTimerRestart,
    output logic [2:0] breakerClosedPin,
    output logic [2:0] currentFlow,
    output logic anyPickup,
    output logic [NSTG-1:0] stageDropout,
    output logic [7:0] restartCount
);
    logic [NSTG-1:0] stagePicked;
    // auxiliary contacts report each group's breaker position, measured current is independent
    assign breakerClosedPin = breakerCmd;
    assign currentFlow = loadOn;
    // a stage shows its dropout condition whenever it is not picked up
    assign stagePicked = faultOn ? pickMask : '0;
    assign anyPickup = |stagePicked;
    assign stageDropout = ~stagePicked;
    // counts restarts of the stage delay timers with their normal durations
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            restartCount <= 8'h00;
        end else if (stageTimerRestart) begin
            restartCount <= restartCount + 8'h01;
        end
    end
endmodule : cls_load_model

// ===== test/tb_cls_switchover.sv
// self-checking testbench for the cold load switchover supervisor
`timescale 1ns/100ps
module tb_cls_switchover;
    import cls_pkg::*;
    localparam int SEC = 10;
    localparam int NSTG = 8;
    localparam logic [31:0] RST_VAL [4] = '{32'h0, 32'hE10, 32'hE10, 32'h258};
    logic core_clk, rst_n, clkEn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rndState;
    logic coldloadBlockIn, fastResetBlockIn, faultOn, anyPickup, stageTimerRestart;
    logic [2:0] breakerCmd, loadOn, breakerClosedPin, currentFlow;
    logic [NSTG-1:0] pickMask, stageDropout;
    logic phaseDynamicActive, residualDynamicActive, earthDynamicActive;
    logic functionOffFlag, functionBlockedFlag, functionRunningFlag;
    logic [7:0] restartCount, rc;
    cls_state_t stateOut;
    int nErrors, totalChecks, n;
    logic [32:0] rdQ [$];

    cls_switchover #(.NSTG(NSTG), .SEC_CYC(SEC), .SCOPE_INCLUDED(1'b1)) i_dut (.core_clk(core_clk),
        .rst_n(rst_n), .clkEn(clkEn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .breakerClosedPin(breakerClosedPin), .currentFlow(currentFlow), .coldloadBlockIn(coldloadBlockIn),
        .fastResetBlockIn(fastResetBlockIn), .anyPickup(anyPickup), .stageDropout(stageDropout),
        .phaseDynamicActive(phaseDynamicActive), .residualDynamicActive(residualDynamicActive),
        .earthDynamicActive(earthDynamicActive), .functionOffFlag(functionOffFlag),
        .functionBlockedFlag(functionBlockedFlag), .functionRunningFlag(functionRunningFlag),
        .stageTimerRestart(stageTimerRestart), .stateOut(stateOut));
    cls_load_model #(.NSTG(NSTG)) i_load (.core_clk(core_clk), .rst_n(rst_n), .breakerCmd(breakerCmd),
        .loadOn(loadOn), .faultOn(faultOn), .pickMask(pickMask), .stageTimerRestart(stageTimerRestart),
        .breakerClosedPin(breakerClosedPin), .currentFlow(currentFlow), .anyPickup(anyPickup),
        .stageDropout(stageDropout), .restartCount(restartCount));

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] xorShift(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction : xorShift
    task automatic stopTest();
        if (nErrors == 0 && totalChecks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : stopTest
    task automatic cmpBus(input logic [32:0] got, input logic [32:0] exp);
        totalChecks++;
        if (got !== exp) begin
            nErrors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmpBus
    task automatic cmpSig(input logic [7:0] got, input logic [7:0] exp);
        totalChecks++;
        if (got !== exp) begin
            nErrors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmpSig
    task automatic chkDyn(input logic e);
        cmpSig({5'h0, phaseDynamicActive, residualDynamicActive, earthDynamicActive}, e ? 8'h07 : 8'h00);
    endtask : chkDyn
    // one apb transfer, held until pready is seen high; read expectations go to the queue
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [32:0] exp);
        int k;
        k = 0;
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        if (!wr) rdQ.push_back(exp);
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50) begin
            nErrors++;
            stopTest();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // waits at falling edges for a state, bounded
    task automatic waitState(input cls_state_t s, input int maxCyc, output int k);
        k = 0;
        while (stateOut !== s && k < maxCyc) begin
            @(negedge core_clk);
            k++;
        end
        if (stateOut !== s) begin
            nErrors++;
            stopTest();
        end
    endtask : waitState

    // read results are compared with the oldest note at the completing edge
    always @(posedge core_clk) begin
        if (psel && penable && pready && !pwrite) cmpBus({pslverr, prdata}, rdQ.pop_front());
    end
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    initial begin
        repeat (20000) @(posedge core_clk);
        nErrors++;
        stopTest();
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        {rst_n, psel, penable, pwrite, coldloadBlockIn, fastResetBlockIn, faultOn} = '0;
        clkEn = 1'b1;
        paddr = '0;
        pwdata = '0;
        breakerCmd = 3'h7;
        loadOn = 3'h7;
        pickMask = '0;
        rndState = 32'h9DFFE91C;
        nErrors = 0;
        totalChecks = 0;
        repeat (20) @(posedge core_clk);
        rst_n <= 1'b1;
        @(negedge core_clk);
        cmpSig({2'h0, functionOffFlag, functionBlockedFlag, functionRunningFlag, stateOut}, 8'h20);
        for (int i = 0; i < 4; i++) apb(1'b0, 12'(i * 4), '0, {1'b0, RST_VAL[i]});
        apb(1'b0, 12'h010, '0, 33'h080);
        apb(1'b1, 12'h010, 32'hFFFFFFFF, '0);
        apb(1'b0, 12'h010, '0, 33'h080);
        apb(1'b0, 12'h020, '0, {1'b1, 32'h0});
        apb(1'b1, 12'h004, 32'h5461, '0);
        apb(1'b0, 12'h004, '0, 33'h5460);
        for (int i = 0; i < 3; i++) begin
            rndState = xorShift(rndState);
            apb(1'b1, 12'h004, {18'h0, rndState[13:0]}, '0);
            apb(1'b0, 12'h004, '0, {19'h0, rndState[13:0]});
        end
        @(posedge core_clk);
        clkEn <= 1'b0;
        @(negedge core_clk);
        cmpSig({7'h0, pready}, 8'h00);
        @(posedge core_clk);
        clkEn <= 1'b1;
        apb(1'b1, 12'h004, 32'h2, '0);
        apb(1'b1, 12'h008, 32'h4, '0);
        apb(1'b1, 12'h00C, 32'h1, '0);
        apb(1'b1, 12'h000, 32'h1, '0);
        @(posedge core_clk);
        @(negedge core_clk);
        cmpSig({2'h0, functionOffFlag, functionBlockedFlag, functionRunningFlag, stateOut}, 8'h08);
        // dead by current, open delay, then dynamic values
        @(posedge core_clk);
        loadOn <= 3'h0;
        waitState(S_OPENW, 10, n);
        repeat (8) @(negedge core_clk);
        cmpSig({5'h0, stateOut}, {5'h0, S_OPENW});
        chkDyn(1'b0);
        waitState(S_DYND, 30, n);
        @(negedge core_clk);
        chkDyn(1'b1);
        apb(1'b0, 12'h010, '0, 33'h27B);
        // active window with fast reset blocked, disabled by infinite stop time, then running
        for (int v = 0; v < 3; v++) begin
            @(posedge core_clk);
            fastResetBlockIn <= (v == 0);
            apb(1'b1, 12'h000, (v == 1) ? 32'h11 : 32'h1, '0);
            repeat (4) @(negedge core_clk);
            @(posedge core_clk);
            loadOn <= 3'h7;
            waitState(S_ACTIVE, 6, n);
            waitState(S_IDLE, 80, n);
            cmpSig({7'h0, n >= 30}, {7'h0, v < 2});
            repeat (2) @(negedge core_clk);
            chkDyn(1'b0);
            @(posedge core_clk);
            fastResetBlockIn <= 1'b0;
            loadOn <= 3'h0;
            waitState(S_DYND, 40, n);
        end
        // pickup during the window keeps dynamic values until dropout
        rndState = xorShift(rndState);
        @(posedge core_clk);
        pickMask <= rndState[NSTG-1:0] | 8'h01;
        faultOn <= 1'b1;
        loadOn <= 3'h7;
        waitState(S_HOLD, 80, n);
        repeat (20) @(negedge core_clk);
        cmpSig({5'h0, stateOut}, {5'h0, S_HOLD});
        chkDyn(1'b1);
        @(posedge core_clk);
        faultOn <= 1'b0;
        waitState(S_IDLE, 5, n);
        // block during a fault with dynamic values in use
        @(posedge core_clk);
        loadOn <= 3'h0;
        waitState(S_DYND, 40, n);
        rc = restartCount;
        @(posedge core_clk);
        faultOn <= 1'b1;
        coldloadBlockIn <= 1'b1;
        waitState(S_IDLE, 8, n);
        repeat (3) @(negedge core_clk);
        cmpSig(restartCount - rc, 8'h01);
        chkDyn(1'b0);
        cmpSig({2'h0, functionOffFlag, functionBlockedFlag, functionRunningFlag, stateOut}, 8'h10);
        @(posedge core_clk);
        coldloadBlockIn <= 1'b0;
        faultOn <= 1'b0;
        // closing before the open delay expires leaves normal values
        waitState(S_OPENW, 10, n);
        @(posedge core_clk);
        loadOn <= 3'h7;
        waitState(S_IDLE, 5, n);
        chkDyn(1'b0);
        // breaker criterion; earth needs unambiguous feedback for it
        apb(1'b1, 12'h000, 32'hF, '0);
        @(posedge core_clk);
        breakerCmd <= 3'h0;
        loadOn <= 3'h4;
        repeat (40) @(negedge core_clk);
        cmpSig({5'h0, stateOut}, {5'h0, S_IDLE});
        apb(1'b1, 12'h000, 32'h2F, '0);
        waitState(S_OPENW, 10, n);
        @(posedge core_clk);
        breakerCmd <= 3'h1;
        waitState(S_IDLE, 8, n);
        // switched off: no switchover even when dead
        apb(1'b1, 12'h000, 32'h0, '0);
        @(posedge core_clk);
        breakerCmd <= 3'h0;
        loadOn <= 3'h0;
        repeat (30) @(negedge core_clk);
        cmpSig({2'h0, functionOffFlag, functionBlockedFlag, functionRunningFlag, stateOut}, 8'h20);
        stopTest();
    end
endmodule : tb_cls_switchover
